// >>> stepper_serial_pkg.sv
// Purpose: Shared constants for the stepper driver serial control port
// Assumes: 12-bit command and status words, MSB first
// Notes: Field positions, reset values and event counts live here
package stepper_serial_pkg;

  typedef logic [11:0] word_type;

  // ------------------------------------------------------------
  // Word size
  // ------------------------------------------------------------
  localparam int WORD_BITS = 12;
  localparam logic [3:0] WORD_COUNT = 4'hC;

  // ------------------------------------------------------------
  // Command word fields
  // ------------------------------------------------------------
  localparam int CMD_A_MIXED = 11;
  localparam int CMD_A_CUR_MSB = 10;
  localparam int CMD_A_CUR_LSB = 7;
  localparam int CMD_A_POL = 6;
  localparam int CMD_B_MIXED = 5;
  localparam int CMD_B_CUR_MSB = 4;
  localparam int CMD_B_CUR_LSB = 1;
  localparam int CMD_B_POL = 0;
  localparam word_type CMD_RESET = 12'h000;
  localparam logic [3:0] CUR_OFF = 4'h0;

  // ------------------------------------------------------------
  // Status word fields
  // ------------------------------------------------------------
  localparam int ST_LOAD_MSB = 11;
  localparam int ST_LOAD_LSB = 9;
  localparam int ST_ONE = 8;
  localparam int ST_OT_OFF = 7;
  localparam int ST_OT_WARN = 6;
  localparam int ST_SUPPLY_LOW = 5;
  localparam int ST_OC_HIGH = 4;
  localparam int ST_OPEN_B = 3;
  localparam int ST_OPEN_A = 2;
  localparam int ST_OC_B = 1;
  localparam int ST_OC_A = 0;
  localparam word_type STATUS_RESET = 12'h100;
  localparam logic [2:0] LOAD_RESET = 3'h0;

  // ------------------------------------------------------------
  // Event counts
  // ------------------------------------------------------------
  localparam logic [5:0] OC_WINDOW_CYCLES = 6'h3F;
  localparam logic [1:0] OC_HIT_LIMIT = 2'h3;
  localparam logic [3:0] OPEN_LOAD_CYCLES = 4'hE;

endpackage : stepper_serial_pkg

// >>> stepper_drive_serial_control.sv
// Purpose: Serial slave port of a two-phase stepper driver
// Assumes: Power stage events arrive as mclk-synchronous pulses
// Notes: Link logic runs on sck; csn and drive_enable_n cross by two flip-flops
//
// Contract
// - Only take part while chip select is low; ignore clock otherwise.
// - Sample input on rising clock edge; change output after falling edge.
// - Command and status words travel most significant bit first.
// - Extra input bits reappear on output twelve clocks later for chaining.
// - Chip select rising copies shift register into control register.
// - With extra bits, last twelve before chip select rise form command.
// - Bit 11 coil A mixed decay, bits 10..7 current, bit 6 polarity.
// - Bit 5 coil B mixed decay, bits 4..1 current, bit 0 polarity.
// - Polarity zero drives first to second output; one reverses; mixed bit enables.
// - Status bits 11..9 load indicator, bit 8 always one.
// - Status bits 7, 6, 5: overtemp off, prewarning, supply undervoltage.
// - Overcurrent flags set after three hit PWM cycles within sixty-three.
// - Open load flags set after fourteen oscillator cycles without switch-off.
// - Coil current codes are plain 4-bit DAC values, full scale fifteen sixteenths.
// - Reset or disable clears all registers and enters standby; disable leaves the pin synchronisers and status snapshot running.
// - Host holds enable low to use the serial port.
// - Load indicator refreshes once per full step.
// - Load value zero stall, one to two high, three to seven lighter.
// - Zero current on both coils clears overcurrent flags and enters standby.
// - Enable high means shutdown with serial logic held in reset.
`timescale 1ns/100ps

module stepper_drive_serial_control (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic csnN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoEnableN,
  input wire logic driveEnableN,
  input wire logic pwmCycleTick,
  input wire logic highSideOcEvent,
  input wire logic coilBOcEvent,
  input wire logic coilAOcEvent,
  input wire logic oscTick,
  input wire logic coilBPwmOff,
  input wire logic coilAPwmOff,
  input wire logic overtempOffFlag,
  input wire logic overtempWarningFlag,
  input wire logic supplyLowFlag,
  input wire logic [2:0] loadSample,
  input wire logic fullStepStrobe,
  output logic coilAMixedDecay,
  output logic [3:0] coilACurrent,
  output logic coilAPolarity,
  output logic coilAOutFirst,
  output logic coilAOutSecond,
  output logic coilBMixedDecay,
  output logic [3:0] coilBCurrent,
  output logic coilBPolarity,
  output logic coilBOutFirst,
  output logic coilBOutSecond,
  output logic standby,
  output logic shutdown,
  output logic [2:0] loadLevel,
  output logic highSideOvercurrentFlag,
  output logic coilBOvercurrentFlag,
  output logic coilAOvercurrentFlag,
  output logic coilBOpenFlag,
  output logic coilAOpenFlag
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  stepper_serial_pkg::word_type shiftReg;
  stepper_serial_pkg::word_type next_shiftReg;
  stepper_serial_pkg::word_type statusHold;
  stepper_serial_pkg::word_type next_statusHold;
  stepper_serial_pkg::word_type command;
  stepper_serial_pkg::word_type next_command;
  logic [3:0] bitCount;
  logic [3:0] next_bitCount;
  logic sdoReg;
  logic next_sdoReg;
  logic fallSeen;
  logic next_fallSeen;
  logic linkRst;
  logic frameRst;
  logic csnMeta;
  logic csnSync;
  logic csnPrev;
  logic ennMeta;
  logic ennSync;
  logic csnRise;
  logic clearOc;
  logic next_coilAOutFirst;
  logic next_coilAOutSecond;
  logic next_coilBOutFirst;
  logic next_coilBOutSecond;
  logic next_standby;
  logic [2:0] next_loadLevel;
  logic [2:0] ocEvent;
  logic [2:0] ocFlag;
  logic [1:0] pwmOff;
  logic [1:0] openFlag;
  logic [1:0] coilOff;

  // Bridge direction from polarity, all off in standby
  function automatic logic [1:0] bridgeDrive(input logic pol, input logic off);
    bridgeDrive = off ? 2'h0 : (pol ? 2'h1 : 2'h2);
  endfunction : bridgeDrive

  // ------------------------------------------------------------
  // Link resets
  // ------------------------------------------------------------
  assign linkRst = sys_rst | driveEnableN;
  assign frameRst = linkRst | csnN;

  // ------------------------------------------------------------
  // Link shift register on sck rising edge
  // ------------------------------------------------------------
  always_comb begin
    next_shiftReg = shiftReg;
    next_bitCount = bitCount;
    if (!csnN) begin
      if (bitCount == 4'h0) begin
        next_shiftReg = {statusHold[stepper_serial_pkg::WORD_BITS-2:0], sdi};
      end else begin
        next_shiftReg = {shiftReg[stepper_serial_pkg::WORD_BITS-2:0], sdi};
      end
      if (bitCount != stepper_serial_pkg::WORD_COUNT) begin
        next_bitCount = bitCount + 4'h1;
      end
    end
  end

  always_ff @(posedge sck or posedge linkRst) begin
    if (linkRst) begin
      shiftReg <= stepper_serial_pkg::CMD_RESET;
    end else begin
      shiftReg <= next_shiftReg;
    end
  end

  always_ff @(posedge sck or posedge frameRst) begin
    if (frameRst) begin
      bitCount <= 4'h0;
    end else begin
      bitCount <= next_bitCount;
    end
  end

  // ------------------------------------------------------------
  // Link output on sck falling edge
  // ------------------------------------------------------------
  always_comb begin
    next_sdoReg = shiftReg[stepper_serial_pkg::WORD_BITS-1];
    next_fallSeen = 1'b1;
  end

  always_ff @(negedge sck or posedge frameRst) begin
    if (frameRst) begin
      sdoReg <= 1'b0;
      fallSeen <= 1'b0;
    end else begin
      sdoReg <= next_sdoReg;
      fallSeen <= next_fallSeen;
    end
  end

  // Status MSB shows before the first falling edge
  assign sdo = fallSeen ? sdoReg : statusHold[stepper_serial_pkg::WORD_BITS-1];
  assign sdoEnableN = csnN | linkRst;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      csnMeta <= 1'b1;
      csnSync <= 1'b1;
      csnPrev <= 1'b1;
      ennMeta <= 1'b1;
      ennSync <= 1'b1;
    end else begin
      csnMeta <= csnN;
      csnSync <= csnMeta;
      csnPrev <= csnSync;
      ennMeta <= driveEnableN;
      ennSync <= ennMeta;
    end
  end

  assign csnRise = csnSync & ~csnPrev;

  // ------------------------------------------------------------
  // Control register and coil drive
  // ------------------------------------------------------------
  always_comb begin
    next_command = command;
    if (ennSync) begin
      next_command = stepper_serial_pkg::CMD_RESET;
    end else if (csnRise) begin
      next_command = shiftReg;
    end
    next_standby = ennSync |
      ((next_command[stepper_serial_pkg::CMD_A_CUR_MSB:stepper_serial_pkg::CMD_A_CUR_LSB] ==
        stepper_serial_pkg::CUR_OFF) &&
       (next_command[stepper_serial_pkg::CMD_B_CUR_MSB:stepper_serial_pkg::CMD_B_CUR_LSB] ==
        stepper_serial_pkg::CUR_OFF));
    {next_coilAOutFirst, next_coilAOutSecond} =
      bridgeDrive(next_command[stepper_serial_pkg::CMD_A_POL], next_standby);
    {next_coilBOutFirst, next_coilBOutSecond} =
      bridgeDrive(next_command[stepper_serial_pkg::CMD_B_POL], next_standby);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      command <= stepper_serial_pkg::CMD_RESET;
      standby <= 1'b1;
      coilAOutFirst <= 1'b0;
      coilAOutSecond <= 1'b0;
      coilBOutFirst <= 1'b0;
      coilBOutSecond <= 1'b0;
    end else begin
      command <= next_command;
      standby <= next_standby;
      coilAOutFirst <= next_coilAOutFirst;
      coilAOutSecond <= next_coilAOutSecond;
      coilBOutFirst <= next_coilBOutFirst;
      coilBOutSecond <= next_coilBOutSecond;
    end
  end

  assign shutdown = ennSync;
  assign coilAMixedDecay = command[stepper_serial_pkg::CMD_A_MIXED];
  assign coilACurrent = command[stepper_serial_pkg::CMD_A_CUR_MSB:stepper_serial_pkg::CMD_A_CUR_LSB];
  assign coilAPolarity = command[stepper_serial_pkg::CMD_A_POL];
  assign coilBMixedDecay = command[stepper_serial_pkg::CMD_B_MIXED];
  assign coilBCurrent = command[stepper_serial_pkg::CMD_B_CUR_MSB:stepper_serial_pkg::CMD_B_CUR_LSB];
  assign coilBPolarity = command[stepper_serial_pkg::CMD_B_POL];

  // Both-zero command arriving clears overcurrent flags
  assign clearOc = csnRise & ~ennSync &
    (shiftReg[stepper_serial_pkg::CMD_A_CUR_MSB:stepper_serial_pkg::CMD_A_CUR_LSB] == stepper_serial_pkg::CUR_OFF) &
    (shiftReg[stepper_serial_pkg::CMD_B_CUR_MSB:stepper_serial_pkg::CMD_B_CUR_LSB] == stepper_serial_pkg::CUR_OFF);

  // ------------------------------------------------------------
  // Overcurrent detectors
  // ------------------------------------------------------------
  assign ocEvent = {highSideOcEvent, coilBOcEvent, coilAOcEvent};

  for (genvar ch = 0; ch < 3; ch++) begin : gen_oc
    logic [5:0] windowCnt;
    logic [5:0] next_windowCnt;
    logic [1:0] hitCnt;
    logic [1:0] next_hitCnt;
    logic flag;
    logic next_flag;

    always_comb begin
      next_windowCnt = windowCnt;
      next_hitCnt = hitCnt;
      next_flag = flag;
      if (clearOc) begin
        next_flag = 1'b0;
      end
      if (ennSync) begin
        next_windowCnt = 6'h00;
        next_hitCnt = 2'h0;
        next_flag = 1'b0;
      end else if (pwmCycleTick) begin
        if (hitCnt == 2'h0) begin
          if (ocEvent[ch]) begin
            next_hitCnt = 2'h1;
            next_windowCnt = 6'h01;
          end
        end else if (ocEvent[ch] && (hitCnt + 2'h1 == stepper_serial_pkg::OC_HIT_LIMIT)) begin
          next_flag = 1'b1;
          next_hitCnt = 2'h0;
          next_windowCnt = 6'h00;
        end else if (windowCnt == stepper_serial_pkg::OC_WINDOW_CYCLES - 6'h01) begin
          next_hitCnt = 2'h0;
          next_windowCnt = 6'h00;
        end else begin
          next_windowCnt = windowCnt + 6'h01;
          next_hitCnt = hitCnt + {1'b0, ocEvent[ch]};
        end
      end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        windowCnt <= 6'h00;
        hitCnt <= 2'h0;
        flag <= 1'b0;
      end else begin
        windowCnt <= next_windowCnt;
        hitCnt <= next_hitCnt;
        flag <= next_flag;
      end
    end

    assign ocFlag[ch] = flag;
  end

  assign {highSideOvercurrentFlag, coilBOvercurrentFlag, coilAOvercurrentFlag} = ocFlag;

  // ------------------------------------------------------------
  // Open load detectors
  // ------------------------------------------------------------
  assign pwmOff = {coilBPwmOff, coilAPwmOff};
  assign coilOff = {coilBCurrent == stepper_serial_pkg::CUR_OFF, coilACurrent == stepper_serial_pkg::CUR_OFF};

  for (genvar cl = 0; cl < 2; cl++) begin : gen_open
    logic [3:0] idleCnt;
    logic [3:0] next_idleCnt;
    logic flag;
    logic next_flag;

    always_comb begin
      next_idleCnt = idleCnt;
      if (ennSync || coilOff[cl] || pwmOff[cl]) begin
        next_idleCnt = 4'h0;
      end else if (oscTick && (idleCnt != stepper_serial_pkg::OPEN_LOAD_CYCLES)) begin
        next_idleCnt = idleCnt + 4'h1;
      end
      next_flag = (next_idleCnt == stepper_serial_pkg::OPEN_LOAD_CYCLES);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        idleCnt <= 4'h0;
        flag <= 1'b0;
      end else begin
        idleCnt <= next_idleCnt;
        flag <= next_flag;
      end
    end

    assign openFlag[cl] = flag;
  end

  assign {coilBOpenFlag, coilAOpenFlag} = openFlag;

  // ------------------------------------------------------------
  // Load indicator and status snapshot
  // ------------------------------------------------------------
  always_comb begin
    next_loadLevel = loadLevel;
    if (ennSync) begin
      next_loadLevel = stepper_serial_pkg::LOAD_RESET;
    end else if (fullStepStrobe) begin
      next_loadLevel = loadSample;
    end
    next_statusHold = statusHold;
    if (csnSync) begin
      next_statusHold[stepper_serial_pkg::ST_LOAD_MSB:stepper_serial_pkg::ST_LOAD_LSB] = loadLevel;
      next_statusHold[stepper_serial_pkg::ST_ONE] = 1'b1;
      next_statusHold[stepper_serial_pkg::ST_OT_OFF] = overtempOffFlag;
      next_statusHold[stepper_serial_pkg::ST_OT_WARN] = overtempWarningFlag;
      next_statusHold[stepper_serial_pkg::ST_SUPPLY_LOW] = supplyLowFlag;
      next_statusHold[stepper_serial_pkg::ST_OC_HIGH] = ocFlag[2];
      next_statusHold[stepper_serial_pkg::ST_OPEN_B] = openFlag[1];
      next_statusHold[stepper_serial_pkg::ST_OPEN_A] = openFlag[0];
      next_statusHold[stepper_serial_pkg::ST_OC_B] = ocFlag[1];
      next_statusHold[stepper_serial_pkg::ST_OC_A] = ocFlag[0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      loadLevel <= stepper_serial_pkg::LOAD_RESET;
      statusHold <= stepper_serial_pkg::STATUS_RESET;
    end else begin
      loadLevel <= next_loadLevel;
      statusHold <= next_statusHold;
    end
  end

endmodule : stepper_drive_serial_control

// >>> spi_host_model.sv
// Purpose: Host side of the serial link, acts as bus master
// Assumes: 125 ns link clock, running only inside frames
// Notes: Data line is inverted after release
`timescale 1ns/100ps

module spi_host_model (
  output logic sck,
  output logic csnN,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdoEnableN
);
  initial begin
    sck = 1'b0;
    csnN = 1'b1;
    sdi = 1'b1;
  end

  task automatic frame(input logic [23:0] tx, input int n, output logic [23:0] rx, output logic drv);
    rx = 24'h000000;
    drv = 1'b1;
    csnN = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #62.5 sck = 1'b1;
      rx[i] = sdo;
      drv = drv & !sdoEnableN;
      #62.5 sck = 1'b0;
    end
    #100 csnN = 1'b1;
    sdi = !sdi;
    #300;
  endtask : frame
endmodule : spi_host_model

// >>> stepper_drive_serial_control_properties.sv
// Purpose: Concurrent checks on the stepper serial port
// Assumes: Top module ports only, mclk domain
// Notes: Bound to the design at the foot of this file
`timescale 1ns/100ps

module stepper_drive_serial_control_properties (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic csnN,
  input wire logic sdoEnableN,
  input wire logic driveEnableN,
  input wire logic pwmCycleTick,
  input wire logic [2:0] loadSample,
  input wire logic fullStepStrobe,
  input wire logic coilAMixedDecay,
  input wire logic [3:0] coilACurrent,
  input wire logic coilAPolarity,
  input wire logic coilAOutFirst,
  input wire logic coilAOutSecond,
  input wire logic coilBMixedDecay,
  input wire logic [3:0] coilBCurrent,
  input wire logic coilBPolarity,
  input wire logic standby,
  input wire logic shutdown,
  input wire logic [2:0] loadLevel,
  input wire logic highSideOvercurrentFlag,
  input wire logic coilBOvercurrentFlag,
  input wire logic coilAOvercurrentFlag,
  input wire logic coilAOpenFlag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_sdo_release;
    sdoEnableN == (csnN | driveEnableN);
  endproperty
  a_sdo_release: assert property (p_sdo_release) else $error("sdo enable wrong");
  property p_drive_a;
    !standby |-> coilAOutFirst == !coilAPolarity && coilAOutSecond == coilAPolarity;
  endproperty
  a_drive_a: assert property (p_drive_a) else $error("coil A direction wrong");
  property p_standby_off;
    standby |-> {coilAOutFirst, coilAOutSecond} == 2'h0;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("coil A driven in standby");
  property p_standby_level;
    $stable({coilACurrent, coilBCurrent, shutdown}) |->
      standby == ((coilACurrent == 4'h0 && coilBCurrent == 4'h0) || shutdown);
  endproperty
  a_standby_level: assert property (p_standby_level) else $error("standby level wrong");
  property p_shutdown_entry;
    $rose(driveEnableN) |-> ##[1:3] shutdown;
  endproperty
  a_shutdown_entry: assert property (p_shutdown_entry) else $error("no shutdown");
  property p_disable_clear;
    driveEnableN [*5] |->
      {coilAMixedDecay, coilACurrent, coilAPolarity, coilBMixedDecay, coilBCurrent, coilBPolarity} == 12'h000 &&
      loadLevel == 3'h0 && !coilAOvercurrentFlag && shutdown;
  endproperty
  a_disable_clear: assert property (p_disable_clear) else $error("disable did not clear");
  property p_load_take;
    fullStepStrobe && !driveEnableN && !shutdown |=> loadLevel == $past(loadSample);
  endproperty
  a_load_take: assert property (p_load_take) else $error("load not taken");
  property p_cmd_hold;
    (!csnN && !driveEnableN && !shutdown) [*5] |->
      $stable({coilAMixedDecay, coilACurrent, coilAPolarity, coilBMixedDecay, coilBCurrent, coilBPolarity});
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command changed in frame");
  property p_oc_clear;
    $fell(coilACurrent != 4'h0 || coilBCurrent != 4'h0) && !pwmCycleTick && !$past(pwmCycleTick) |->
      ##[0:1] !coilAOvercurrentFlag && !coilBOvercurrentFlag && !highSideOvercurrentFlag;
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("overcurrent not cleared");
  property p_open_zero;
    (coilACurrent == 4'h0) [*2] |-> !coilAOpenFlag;
  endproperty
  a_open_zero: assert property (p_open_zero) else $error("open flag at zero current");
endmodule : stepper_drive_serial_control_properties

bind stepper_drive_serial_control stepper_drive_serial_control_properties stepper_drive_serial_control_properties_i (
  .mclk, .sys_rst, .csnN, .sdoEnableN, .driveEnableN, .pwmCycleTick, .loadSample, .fullStepStrobe, .coilAMixedDecay,
  .coilACurrent, .coilAPolarity, .coilAOutFirst, .coilAOutSecond, .coilBMixedDecay, .coilBCurrent, .coilBPolarity,
  .standby, .shutdown, .loadLevel, .highSideOvercurrentFlag, .coilBOvercurrentFlag, .coilAOvercurrentFlag, .coilAOpenFlag);

// >>> stepper_drive_serial_control_tb_top.sv
// Purpose: Self-checking bench for the stepper serial port
// Assumes: Host model drives the link at 125 ns
// Notes: Design inputs other than the link pins change on mclk rising edges
`timescale 1ns/100ps

module stepper_drive_serial_control_tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic driveEnableN = 1'b1;
  logic sck, csnN, sdi, sdo, sdoEnableN, drv;
  logic pwmCycleTick = 1'b0, coilAOcEvent = 1'b0, coilBOcEvent = 1'b0, highSideOcEvent = 1'b0, oscTick = 1'b0;
  logic coilBPwmOff = 1'b0, coilAPwmOff = 1'b0, fullStepStrobe = 1'b0;
  logic overtempOffFlag = 1'b0, overtempWarningFlag = 1'b0, supplyLowFlag = 1'b0;
  logic [2:0] loadSample = 3'h0;
  logic coilAMixedDecay, coilAPolarity, coilAOutFirst, coilAOutSecond, coilBMixedDecay, coilBPolarity;
  logic coilBOutFirst, coilBOutSecond, standby, shutdown, highSideOvercurrentFlag, coilBOvercurrentFlag;
  logic coilAOvercurrentFlag, coilBOpenFlag, coilAOpenFlag;
  logic [3:0] coilACurrent, coilBCurrent;
  logic [2:0] loadLevel;
  logic [23:0] rx;
  int nMismatch = 0;
  int checkCount = 0;

  always #12.5 mclk = ~mclk;

  stepper_drive_serial_control stepper_drive_serial_control_i (.mclk, .sys_rst, .sck, .csnN, .sdi, .sdo, .sdoEnableN,
    .driveEnableN, .pwmCycleTick, .highSideOcEvent, .coilBOcEvent, .coilAOcEvent, .oscTick, .coilBPwmOff, .coilAPwmOff,
    .overtempOffFlag, .overtempWarningFlag, .supplyLowFlag, .loadSample, .fullStepStrobe, .coilAMixedDecay,
    .coilACurrent, .coilAPolarity, .coilAOutFirst, .coilAOutSecond, .coilBMixedDecay, .coilBCurrent, .coilBPolarity,
    .coilBOutFirst, .coilBOutSecond, .standby, .shutdown, .loadLevel, .highSideOvercurrentFlag, .coilBOvercurrentFlag,
    .coilAOvercurrentFlag, .coilBOpenFlag, .coilAOpenFlag);
  spi_host_model spi_host_model_i (.sck, .csnN, .sdi, .sdo, .sdoEnableN);

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  function automatic logic [11:0] cmdOut();
    return {coilAMixedDecay, coilACurrent, coilAPolarity, coilBMixedDecay, coilBCurrent, coilBPolarity};
  endfunction : cmdOut

  task automatic send(input logic [23:0] tx, input int n);
    spi_host_model_i.frame(tx, n, rx, drv);
    repeat (6) @(posedge mclk);
  endtask : send

  // Pulse of {pwm, A hit, B hit, high-side hit, osc}
  task automatic pulse(input logic [4:0] v);
    @(posedge mclk);
    {pwmCycleTick, coilAOcEvent, coilBOcEvent, highSideOcEvent, oscTick} <= v;
    @(posedge mclk);
    {pwmCycleTick, coilAOcEvent, coilBOcEvent, highSideOcEvent, oscTick} <= 5'h00;
  endtask : pulse

  task automatic t_commands();
    logic [11:0] w [4] = '{12'h7BF, 12'hC42, 12'h800, 12'h041};
    logic st;
    foreach (w[i]) begin
      st = (w[i][10:7] == 4'h0) && (w[i][4:1] == 4'h0);
      send({12'h000, w[i]}, 12);
      check("status", rx[11:0], 12'h100);
      check("command", cmdOut(), w[i]);
      check("drive", {standby, coilAOutFirst, coilAOutSecond, coilBOutFirst, coilBOutSecond},
        {st, st ? 4'h0 : {!w[i][6], w[i][6], !w[i][0], w[i][0]}});
      check("release", {drv, sdoEnableN}, 2'h3);
    end
    send(24'h00A5C3, 16);
    check("chain", rx[3:0], 4'hA);
    check("last word", cmdOut(), 12'h5C3);
    $display("done commands");
  endtask : t_commands

  task automatic t_status();
    logic [5:0] v;
    repeat (400) @(posedge mclk);
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 6'h2D : 6'h12;
      @(posedge mclk);
      {loadSample, overtempOffFlag, overtempWarningFlag, supplyLowFlag} <= v;
      fullStepStrobe <= 1'b1;
      @(posedge mclk);
      fullStepStrobe <= 1'b0;
      repeat (4) @(posedge mclk);
      check("load", loadLevel, v[5:3]);
      send(24'h000000, 12);
      check("status", rx[11:0], {v[5:3], 1'b1, v[2:0], 5'h00});
    end
    {overtempOffFlag, overtempWarningFlag, supplyLowFlag} <= 3'h0;
    $display("done status");
  endtask : t_status

  task automatic t_faults();
    send(24'h0007BF, 12);
    pulse(5'h1E);
    pulse(5'h1E);
    pulse(5'h1A);
    repeat (2) @(posedge mclk);
    check("oc flags", {highSideOvercurrentFlag, coilBOvercurrentFlag, coilAOvercurrentFlag}, 3'h5);
    send(24'h000000, 12);
    check("oc status", rx[11:0], 12'h511);
    check("oc clear", {highSideOvercurrentFlag, coilBOvercurrentFlag, coilAOvercurrentFlag, standby}, 4'h1);
    send(24'h0007BF, 12);
    repeat (13) pulse(5'h01);
    repeat (2) @(posedge mclk);
    check("open early", {coilBOpenFlag, coilAOpenFlag}, 2'h0);
    pulse(5'h01);
    repeat (2) @(posedge mclk);
    check("open set", {coilBOpenFlag, coilAOpenFlag}, 2'h3);
    coilAPwmOff <= 1'b1;
    @(posedge mclk);
    coilAPwmOff <= 1'b0;
    repeat (2) @(posedge mclk);
    check("open drop", {coilBOpenFlag, coilAOpenFlag}, 2'h2);
    $display("done faults");
  endtask : t_faults

  task automatic t_shutdown();
    driveEnableN <= 1'b1;
    repeat (6) @(posedge mclk);
    check("off", {shutdown, standby, sdoEnableN, coilBOpenFlag, loadLevel}, 7'h70);
    send(24'h0007BF, 12);
    check("ignored", {drv, cmdOut()}, 13'h0000);
    driveEnableN <= 1'b0;
    repeat (8) @(posedge mclk);
    send(24'h000C42, 12);
    check("resumed", cmdOut(), 12'hC42);
    $display("done shutdown");
  endtask : t_shutdown

  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    driveEnableN <= 1'b0;
    repeat (8) @(posedge mclk);
    check("reset", {cmdOut(), standby, loadLevel}, 16'h0008);
    t_commands();
    t_status();
    t_faults();
    t_shutdown();
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge mclk);
    nMismatch++;
    complete_run();
  end
endmodule : stepper_drive_serial_control_tb_top
